// ---- include/hrf_map.svh ----
// Address map, field positions, reset values and sizes of the host port.
// Assumes byte addresses on an 8-bit host address bus.
`ifndef HRF_MAP_SVH
`define HRF_MAP_SVH
`define HRF_AW 8
`define HRF_DEPTH 16
`define HRF_PW 4
`define HRF_CW 5
`define HRF_RXD_SEL 7:5
`define HRF_RXD_HIT 3'h0
`define HRF_A_RXS 8'h40
`define HRF_A_RXSP 8'h44
`define HRF_A_STS 8'h50
`define HRF_A_CFG 8'h54
`define HRF_A_CMD 8'h58
`define HRF_A_ID 8'h5c
`define HRF_HALF_BIT 1
`define HRF_STS_RO 7:0
`define HRF_STS_W1C 15:8
`define HRF_STS_RC 23:16
`define HRF_STS_LL 24
`define HRF_STS_LH 25
`define HRF_CFG_RXS 3:0
`define HRF_CFG_RXD 7:4
`define HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET 15:8
`define HRF_CFG_SRST 31
`define HRF_CFG_RST 16'h00ff
`define HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET_MASK 16'hff00
`define HRF_LL_RST 1'b1
`define HRF_LH_RST 1'b0
`define HRF_LO16 32'h0000ffff
`define HRF_HI16 32'hffff0000
`define HRF_ALL32 32'hffffffff
`endif

// ---- include/hrf_pkg.sv ----
// Types shared by the host port and its FIFOs.
// Assumes hrf_map.svh is on the include path.
`include "hrf_map.svh"
package hrf_pkg;
  typedef logic [31:0] hrf_word_t;
  typedef logic [`HRF_PW-1:0] hrf_ptr_t;
  typedef logic [`HRF_CW-1:0] hrf_cnt_t;
  typedef struct packed {
    hrf_ptr_t wp;
    hrf_ptr_t rp;
    hrf_cnt_t cnt;
    logic ready;
  } hrf_fifo_s;
  typedef struct packed {
    hrf_word_t rdata;
    logic rvalid;
    logic [15:0] cfg;
    hrf_word_t cmd;
    logic cmd_pulse;
    logic [7:0] w1c;
    logic [7:0] rc;
    logic ll;
    logic lh;
    logic half;
    logic srst;
  } hrf_top_s;
endpackage

// ---- include/hrf_fifo_if.sv ----
// Link between the host port logic and one receive FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface hrf_fifo_if;
  import hrf_pkg::*;
  logic push_valid;
  logic push_ready;
  hrf_word_t push_data;
  logic pop;
  logic clr;
  hrf_cnt_t lim;
  hrf_word_t head;
  logic empty;
  modport fifo_mp(input push_valid, push_data, pop, clr, lim, output push_ready, head, empty);
  modport user_mp(output push_valid, push_data, pop, clr, lim, input push_ready, head, empty);
endinterface

// ---- design/hrf_fifo.sv ----
// Receive FIFO with a fixed array and a software-set fill limit.
// Assumes pop is only meaningful while not empty.
`timescale 1ns/1ns
`include "hrf_map.svh"
module hrf_fifo
  import hrf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Push and pop link
  hrf_fifo_if.fifo_mp f
);
  hrf_word_t mem [0:`HRF_DEPTH-1];
  hrf_fifo_s s, n;
  logic push, pop;

  always_comb begin
    push = f.push_valid && s.ready;
    pop = f.pop && (s.cnt != '0);
    n = s;
    if (push) begin
      n.wp = s.wp + 4'h1;
    end
    if (pop) begin
      n.rp = s.rp + 4'h1;
    end
    n.cnt = s.cnt + {4'h0, push} - {4'h0, pop};
    // Ready is a flop; a lowered limit may admit one extra word
    n.ready = n.cnt < f.lim;
    if (f.clr) begin
      n = '0;
      n.ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.ready <= 1'b1;
    end else begin
      s <= n;
      if (push) begin
        mem[s.wp] <= f.push_data;
      end
    end
  end

  assign f.push_ready = s.ready;
  assign f.head = mem[s.rp];
  assign f.empty = (s.cnt == '0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  pop_count_a: assert property (f.pop && !f.empty && !push && !f.clr |=> s.cnt == $past(s.cnt) - 5'h1)
    else $error("pop did not remove the head");
  no_overfill_a: assert property (s.cnt <= `HRF_DEPTH)
    else $error("fifo count above depth");
  fill_c: cover property (!s.ready);
endmodule

// ---- design/hrf_top.sv ----
// Host register and receive FIFO port logic of the network controller.
// Assumes host strobes are one-cycle pulses on clk from same-clock logic.
`timescale 1ns/1ns
`include "hrf_map.svh"
module hrf_top
  import hrf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host bus
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [`HRF_AW-1:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic bus16,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  // Receive status FIFO fill side
  input wire logic rxs_valid,
  input wire logic [31:0] rxs_data,
  output logic rxs_ready,
  // Receive data FIFO fill side
  input wire logic rxd_valid,
  input wire logic [31:0] rxd_data,
  output logic rxd_ready,
  // Status sources
  input wire logic [7:0] sts_live,
  input wire logic [7:0] evt_w1c,
  input wire logic [7:0] evt_rc,
  input wire logic cond_ll,
  input wire logic cond_lh,
  // Configuration and command outputs
  output logic [15:0] cfg_bits,
  output logic [31:0] cmd_word,
  output logic cmd_strobe,
  output logic soft_reset_pulse
);
  localparam hrf_word_t ID_CODE = 32'h00c0ffee; // Arbitrary identity value

  hrf_fifo_if rxs_if ();
  hrf_fifo_if rxd_if ();
  hrf_top_s s, n;
  hrf_word_t rv, wd, wm;
  logic rxd_hit, rd_sts;
  logic [`HRF_AW-1:0] da;

  // Picks a 16-bit half for the narrow bus mode
  function automatic hrf_word_t sel16(input hrf_word_t v, input logic hi, input logic narrow);
    if (!narrow) begin
      sel16 = v;
    end else if (hi) begin
      sel16 = {16'h0000, v[31:16]};
    end else begin
      sel16 = {16'h0000, v[15:0]};
    end
  endfunction

  hrf_fifo u_rxs (.clk(clk), .reset(reset), .f(rxs_if.fifo_mp));
  hrf_fifo u_rxd (.clk(clk), .reset(reset), .f(rxd_if.fifo_mp));

  assign rxs_if.push_valid = rxs_valid;
  assign rxs_if.push_data = rxs_data;
  assign rxd_if.push_valid = rxd_valid;
  assign rxd_if.push_data = rxd_data;
  assign rxs_if.clr = s.srst;
  assign rxd_if.clr = s.srst;
  assign rxs_if.lim = {1'b0, s.cfg[`HRF_CFG_RXS]} + 5'h01;
  assign rxd_if.lim = {1'b0, s.cfg[`HRF_CFG_RXD]} + 5'h01;

  always_comb begin
    // Narrow mode drops the half-select bit so both halves decode one register
    da = host_addr;
    if (bus16) begin
      da[`HRF_HALF_BIT] = 1'b0;
    end
    rxd_hit = (host_addr[`HRF_RXD_SEL] == `HRF_RXD_HIT);
    rd_sts = host_rd && (da == `HRF_A_STS);
    // Narrow writes land in the half picked by the address
    wd = bus16 ? {host_wdata[15:0], host_wdata[15:0]} : host_wdata;
    wm = !bus16 ? `HRF_ALL32 : (host_addr[`HRF_HALF_BIT] ? `HRF_HI16 : `HRF_LO16);
    case (da)
      `HRF_A_RXS, `HRF_A_RXSP: rv = rxs_if.empty ? '0 : rxs_if.head;
      `HRF_A_STS: rv = {6'h00, s.lh, s.ll, s.rc, s.w1c, sts_live};
      `HRF_A_CFG: rv = {16'h0000, s.cfg};
      `HRF_A_CMD: rv = '0;
      `HRF_A_ID: rv = ID_CODE;
      default: rv = '0; // Reserved space reads zero
    endcase
    // Narrow data reads take low half then high half and pop on the second; status reads pop on the high half address
    rxs_if.pop = host_rd && (da == `HRF_A_RXS) && (!bus16 || host_addr[`HRF_HALF_BIT]);
    rxd_if.pop = host_rd && rxd_hit && (!bus16 || s.half);

    n = s;
    n.rvalid = 1'b0;
    n.cmd_pulse = 1'b0;
    n.srst = 1'b0;
    // Events win over a clear in the same cycle
    n.w1c = s.w1c | evt_w1c;
    n.rc = s.rc | evt_rc;
    n.ll = s.ll & cond_ll;
    n.lh = s.lh | cond_lh;
    if (host_rd) begin
      n.rvalid = 1'b1;
      if (rxd_hit) begin
        n.rdata = rxd_if.empty ? '0 : sel16(rxd_if.head, s.half, bus16);
        if (bus16 && !rxd_if.empty) begin
          n.half = !s.half;
        end
      end else begin
        n.rdata = sel16(rv, host_addr[`HRF_HALF_BIT], bus16);
      end
      if (rd_sts) begin
        n.rc = evt_rc;
        n.ll = cond_ll;
        n.lh = cond_lh;
      end
    end
    if (host_wr) begin
      case (da)
        `HRF_A_STS: n.w1c = (s.w1c & ~(wd[`HRF_STS_W1C] & wm[`HRF_STS_W1C])) | evt_w1c;
        `HRF_A_CFG: begin
          n.cfg = (s.cfg & ~wm[15:0]) | (wd[15:0] & wm[15:0]);
          n.srst = wd[`HRF_CFG_SRST] & wm[`HRF_CFG_SRST];
        end
        `HRF_A_CMD: begin
          n.cmd = (s.cmd & ~wm) | (wd & wm);
          n.cmd_pulse = 1'b1;
        end
        default: n.cmd_pulse = 1'b0; // Read-only and reserved space keep state
      endcase
    end
    // Accesses in the pulse cycle are dropped and all state but cfg bits 15:8 reloads its reset value
    if (s.srst) begin
      n = '0;
      n.cfg = (`HRF_CFG_RST & ~`HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET_MASK) | (s.cfg & `HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET_MASK);
      n.ll = `HRF_LL_RST;
      n.lh = `HRF_LH_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.cfg <= `HRF_CFG_RST;
      s.ll <= `HRF_LL_RST;
      s.lh <= `HRF_LH_RST;
    end else begin
      s <= n;
    end
  end

  assign host_rdata = s.rdata;
  assign host_rvalid = s.rvalid;
  assign rxs_ready = rxs_if.push_ready;
  assign rxd_ready = rxd_if.push_ready;
  assign cfg_bits = s.cfg;
  assign cmd_word = s.cmd;
  assign cmd_strobe = s.cmd_pulse;
  assign soft_reset_pulse = s.srst;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ro_ignore_a: assert property (host_wr && !host_rd && !s.srst && host_addr == `HRF_A_STS
    |=> s.rc == ($past(s.rc) | $past(evt_rc)))
    else $error("write altered read-only status");
  wo_zero_a: assert property (host_rd && !s.srst && host_addr == `HRF_A_CMD |=> host_rvalid && host_rdata == '0)
    else $error("write-only register read nonzero");
  w1c_clear_a: assert property (host_wr && !bus16 && !s.srst && host_addr == `HRF_A_STS && host_wdata[8]
    && !evt_w1c[0] |=> !s.w1c[0])
    else $error("write of one did not clear");
  w1c_keep_a: assert property (host_wr && host_addr == `HRF_A_STS && !host_wdata[8] && s.w1c[0] && !s.srst
    |=> s.w1c[0])
    else $error("write of zero cleared bit");
  rc_clear_a: assert property (rd_sts && !evt_rc[0] && !s.srst |=> !s.rc[0])
    else $error("read did not clear bit");
  ll_hold_a: assert property (!s.ll && !rd_sts && !s.srst |=> !s.ll)
    else $error("latched low released without read");
  keeps_value_on_soft_reset_keep_a: assert property (s.srst |=> s.cfg[`HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET] == $past(s.cfg[`HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET]))
    else $error("protected bits lost on soft reset");
  srst_dflt_a: assert property (s.srst |=> s.w1c == '0 && rxs_if.empty
    && (s.cfg & ~`HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET_MASK) == (`HRF_CFG_RST & ~`HRF_CFG_KEEPS_VALUE_ON_SOFT_RESET_MASK))
    else $error("soft reset missed defaults");
  peek_keep_a: assert property (host_rd && host_addr == `HRF_A_RXSP |-> !rxs_if.pop)
    else $error("peek popped the fifo");
  alias_pop_a: assert property (host_rd && !bus16 && !s.srst && rxd_hit |-> rxd_if.pop ##1 host_rvalid)
    else $error("data alias read did not pop");
  // Read-back checks leave out the soft reset pulse, which drops any access
  lh_hold_a: assert property (s.lh && !rd_sts && !s.srst |=> s.lh)
    else $error("latched high released without read");
  rc_hold_a: assert property (s.rc[0] && !rd_sts && !s.srst |=> s.rc[0])
    else $error("read-clear bit lost without read");
  id_fixed_a: assert property (host_rd && !bus16 && !s.srst && host_addr == `HRF_A_ID
    |=> host_rdata == ID_CODE)
    else $error("identity register changed");
  live_ro_a: assert property (host_rd && !bus16 && !s.srst && host_addr == `HRF_A_STS
    |=> host_rdata[`HRF_STS_RO] == $past(sts_live))
    else $error("read-only status not live");
  peek_data_a: assert property (host_rd && !bus16 && !s.srst && host_addr == `HRF_A_RXSP && !rxs_if.empty
    |=> host_rdata == $past(rxs_if.head))
    else $error("peek returned wrong entry");
  half_nopop_a: assert property (host_rd && bus16 && rxd_hit && !s.half |-> !rxd_if.pop)
    else $error("low half read popped data");
  empty_read_a: assert property (host_rd && rxd_hit && rxd_if.empty && !s.srst |=> host_rdata == '0)
    else $error("empty data read not zero");
  cmd_pulse_a: assert property (host_wr && !bus16 && !s.srst && host_addr == `HRF_A_CMD
    |=> cmd_strobe && cmd_word == $past(host_wdata))
    else $error("command write not taken");
  peek_c: cover property (host_rd && host_addr == `HRF_A_RXSP && !rxs_if.empty);
  pop16_c: cover property (host_rd && bus16 && rxd_hit && s.half && !rxd_if.empty);
  srst_c: cover property (s.srst);
  w1c_c: cover property (host_wr && host_addr == `HRF_A_STS && s.w1c != '0);
endmodule

// ---- tb/hrf_host_model.sv ----
// Host CPU model driving one-cycle read and write strobes.
// Assumes the port answers a read one cycle after the strobe.
`timescale 1ns/1ns
`include "hrf_map.svh"
module hrf_host_model (
  // Clock
  input wire logic clk,
  // Host bus
  output logic host_rd,
  output logic host_wr,
  output logic [`HRF_AW-1:0] host_addr,
  output logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic host_rvalid
);
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 8'hff;
    host_wdata = 32'h0;
  end
  // Callers keep reserved bits zero and never write reserved places
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk);
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  // Released address shows the inverse, never a stale value
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(negedge clk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge clk);
    v = host_rvalid;
    d = host_rdata;
    host_rd = 1'b0;
    host_addr = ~a;
  endtask
endmodule

// ---- tb/hrf_top_tb.sv ----
// Self-checking bench for the host port and receive FIFOs.
// Assumes the host model and the design share one clock.
`timescale 1ns/1ns
`include "hrf_map.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module hrf_top_tb;
  import hrf_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic host_rd, host_wr, host_rvalid, cmd_strobe, soft_reset_pulse;
  logic [7:0] host_addr;
  logic [31:0] host_wdata, host_rdata, cmd_word;
  logic bus16 = 1'b0;
  logic rxs_valid = 1'b0;
  logic rxd_valid = 1'b0;
  logic rxs_ready, rxd_ready;
  logic [31:0] rxs_data = 32'h0;
  logic [31:0] rxd_data = 32'h0;
  logic [7:0] sts_live = 8'h5a;
  logic [7:0] evt_w1c = 8'h00;
  logic [7:0] evt_rc = 8'h00;
  logic cond_ll = 1'b1;
  logic cond_lh = 1'b0;
  logic [15:0] cfg_bits;
  int n_mismatch = 0;
  int total_checks = 0;
  hrf_word_t d;
  logic v;
  always #25 clk = ~clk;
  hrf_host_model i_hrf_host_model (.clk, .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata, .host_rvalid);
  hrf_top i_hrf_top (.clk, .reset, .host_rd, .host_wr, .host_addr, .host_wdata, .bus16, .host_rdata,
    .host_rvalid, .rxs_valid, .rxs_data, .rxs_ready, .rxd_valid, .rxd_data, .rxd_ready, .sts_live,
    .evt_w1c, .evt_rc, .cond_ll, .cond_lh, .cfg_bits, .cmd_word, .cmd_strobe, .soft_reset_pulse);
  task automatic close_out;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rdc(input logic [7:0] a, input hrf_word_t e);
    i_hrf_host_model.rd(a, d, v);
    `CHK(v, 1'b1);
    `CHK(d, e);
  endtask
  task automatic wr(input logic [7:0] a, input hrf_word_t w);
    i_hrf_host_model.wr(a, w);
  endtask
  // Ready is a flop, so the level seen before the edge decides acceptance
  task automatic push(input logic sel, input hrf_word_t w, output logic ok);
    @(negedge clk);
    if (sel) begin
      rxd_valid = 1'b1;
      rxd_data = w;
    end else begin
      rxs_valid = 1'b1;
      rxs_data = w;
    end
    ok = sel ? rxd_ready : rxs_ready;
    @(negedge clk);
    rxd_valid = 1'b0;
    rxs_valid = 1'b0;
    rxd_data = ~w;
    rxs_data = ~w;
  endtask
  task automatic t_regs;
    rdc(`HRF_A_CFG, 32'h000000ff);
    `CHK(cfg_bits, 16'h00ff);
    rdc(`HRF_A_STS, 32'h0100005a);
    rdc(`HRF_A_ID, 32'h00c0ffee);
    wr(`HRF_A_ID, 32'hff3f0011);
    rdc(`HRF_A_ID, 32'h00c0ffee);
    wr(`HRF_A_STS, 32'h000000ff);
    rdc(`HRF_A_STS, 32'h0100005a);
    wr(`HRF_A_CMD, 32'h12345678);
    `CHK(cmd_strobe, 1'b1);
    `CHK(cmd_word, 32'h12345678);
    rdc(`HRF_A_CMD, 32'h0);
  endtask
  task automatic t_status;
    @(negedge clk);
    evt_w1c = 8'hff;
    @(negedge clk);
    evt_w1c = 8'h00;
    rdc(`HRF_A_STS, 32'h0100ff5a);
    wr(`HRF_A_STS, 32'h00000e00);
    rdc(`HRF_A_STS, 32'h0100f15a);
    wr(`HRF_A_STS, 32'h00000100);
    rdc(`HRF_A_STS, 32'h0100f05a);
    @(negedge clk);
    evt_rc = 8'h3d;
    cond_ll = 1'b0;
    cond_lh = 1'b1;
    @(negedge clk);
    evt_rc = 8'h00;
    cond_ll = 1'b1;
    cond_lh = 1'b0;
    repeat (3) @(negedge clk);
    rdc(`HRF_A_STS, 32'h023df05a);
    rdc(`HRF_A_STS, 32'h0100f05a);
  endtask
  task automatic t_rx;
    int n;
    logic ok;
    for (int i = 0; i < 3; i++) begin
      push(1'b0, 32'h50000000 + i, ok);
    end
    rdc(`HRF_A_RXSP, 32'h50000000);
    rdc(`HRF_A_RXSP, 32'h50000000);
    rdc(`HRF_A_RXS, 32'h50000000);
    rdc(`HRF_A_RXSP, 32'h50000001);
    rdc(`HRF_A_RXS, 32'h50000001);
    rdc(`HRF_A_RXS, 32'h50000002);
    rdc(`HRF_A_RXS, 32'h0);
    wr(`HRF_A_CFG, 32'h000000f1);
    n = 0;
    for (int i = 0; i < 4; i++) begin
      push(1'b0, 32'h60000000 + i, ok);
      n += int'(ok);
    end
    `CHK(n, 2);
    for (int i = 0; i < 9; i++) begin
      push(1'b1, 32'ha0000000 + i, ok);
    end
    for (int i = 0; i < 8; i++) begin
      rdc(8'(i * 4), 32'ha0000000 + i);
    end
    rdc(8'h20, 32'h0);
    rdc(8'h1c, 32'ha0000008);
    rdc(8'h04, 32'h0);
    bus16 = 1'b1;
    push(1'b1, 32'hbbbbaaaa, ok);
    push(1'b1, 32'hddddcccc, ok);
    rdc(8'h00, 32'h0000aaaa);
    rdc(8'h1e, 32'h0000bbbb);
    rdc(8'h02, 32'h0000cccc);
    rdc(8'h10, 32'h0000dddd);
    wr(8'h5a, 32'h0000beef);
    `CHK(cmd_word, 32'hbeef5678);
    rdc(`HRF_A_RXS, 32'h00000000);
    rdc(8'h42, 32'h00006000);
    rdc(`HRF_A_RXSP, 32'h00000001);
    rdc(8'h42, 32'h00006000);
    rdc(8'h42, 32'h00000000);
    rdc(`HRF_A_STS, 32'h0000f05a);
    rdc(8'h52, 32'h00000100);
    bus16 = 1'b0;
  endtask
  task automatic t_soft;
    wr(`HRF_A_CFG, 32'h0000a533);
    wr(`HRF_A_CFG, 32'h8000a533);
    `CHK(soft_reset_pulse, 1'b1);
    rdc(`HRF_A_CFG, 32'h0000a5ff);
    `CHK(cmd_word, 32'h0);
    rdc(`HRF_A_STS, 32'h0100005a);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    `CHK(cfg_bits, 16'h00ff);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_status();
    t_rx();
    t_soft();
    close_out();
  end
endmodule
